// ==== inc/sfs_regs.svh ====
/*
 * register offsets, field positions, reset values and timing figures
 * of the supply fault supervisor. assumes a 50 MHz core clock.
 */
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH
`define SFS_CLK_MHZ 50
`define SFS_OV_DEB_NS 16000
`define SFS_UV_DEB_US 450
`define SFS_SUPPLY_ON_REQUEST_DEB_MS 80
`define SFS_ON_DELAY_MS 100
`define SFS_OFF_DELAY_MS 2
`define SFS_RESTART_MS 1000
`define SFS_CFG_WAIT_MS 20
`define SFS_OCP_TIME_MS 10
`define SFS_SS_STEP_US 100
`define SFS_SS_STEPS 7'h7F
`define SFS_ADR_CTRL 8'h00
`define SFS_ADR_OFFD 8'h04
`define SFS_ADR_OCPT 8'h08
`define SFS_ADR_PSOND 8'h0C
`define SFS_ADR_SSSTEP 8'h10
`define SFS_ADR_STATUS 8'h14
`define SFS_CTRL_AUTO 0
`define SFS_CTRL_SRC_LO 1
`define SFS_CTRL_BUS_AC 3
`define SFS_CTRL_DC_PU 4
`define SFS_CTRL_DC_INV 5
`define SFS_CTRL_AC_PU 6
`define SFS_CTRL_AC_INV 7
`define SFS_CTRL_CLR 9
`define SFS_CTRL_RST 10'h000
`endif

// ==== inc/sfs_pkg.sv ====
/*
 * types of the supply fault supervisor.
 * assumes sfs_regs.svh for all numeric figures.
 */
package sfs_pkg;
  typedef enum logic [6:0]
  {
    ST_CFG = 7'h01,
    ST_OFF = 7'h02,
    ST_RAMP = 7'h04,
    ST_RUN = 7'h08,
    ST_DROP = 7'h10,
    ST_LATCH = 7'h20,
    ST_RETRY = 7'h40
  } sfs_state_t;
  typedef enum logic [1:0]
  {
    DR_SUPPLY_ON_REQUEST = 2'h0,
    DR_UV = 2'h1,
    DR_FAULT = 2'h2
  } sfs_drop_t;
  typedef enum logic [1:0]
  {
    AC_CHIP = 2'h0,
    AC_BUS = 2'h1,
    AC_LINK = 2'h2,
    AC_ALT = 2'h3
  } sfs_acsrc_t;
endpackage

// ==== verilog/sfs_supervisor.sv ====
/*
 * supply fault supervisor: debounce, shutdown latch, sequencing of
 * power_enable, crowbar, ORing gate and good flags, soft-start steps.
 * assumes comparator inputs already digital, classic wishbone master,
 * testbench resolves the open-drain pins from the enables.
 */
// Operation
// [R1] reset clears every latch and starts from a defined state
// [R2] undervoltage drops power_enable after the delay, then latches or retries
// [R3] undervoltage drops output_good_flag at once
// [R4] overvoltage latches, drops power_enable, fires crowbar, drops good flag
// [R5] overvoltage always latches; cleared by supply_on cycle, reset or bus
// [R6] lasting overcurrent shuts down through the shared latch, timeout set by bus
// [R7] overtemperature shuts down through the shared latch, good flag first
// [R8] undervoltage blanked during power-up and while line is low
// [R9] constant current overload blanks undervoltage for the ride-through
// [R10] line status from chip input, bus write or shared link pin
// [R11] output_good_flag held false for the turn-on delay
// [R12] supply_on low, overcurrent, overtemperature: good flag first, enable later
// [R13] inputs debounced: 16 us over, 450 us under, 80 ms supply_on
// [R14] good flags configurable pull-up or pull-down and inverted
// [R15] line returning good starts a full power-up
// [R16] ORing gate driven only while transformer pulse is good
// [R17] alternate line low drops input_good_flag, output flag stays
// [R18] reference ramps from zero in 127 steps at start-up
// [R19] aux overvoltage acts as overvoltage, aux lockout as undervoltage
// [R20] auto-restart every second, after undervoltage only
// [R21] ground monitor fault latches off like overvoltage
// [R22] low external reference removes power_enable
// [R23] enable, crowbar and gate released until configuration ends
// [R24] every input passes two flip-flops before debounce
// [R25] all timing counts on the single core clock
`include "sfs_regs.svh"
module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int OV_DEB = (`SFS_OV_DEB_NS * `SFS_CLK_MHZ + 999) / 1000,
  parameter int UV_DEB = `SFS_UV_DEB_US * `SFS_CLK_MHZ,
  parameter int SUPPLY_ON_REQUEST_DEB = `SFS_SUPPLY_ON_REQUEST_DEB_MS * 1000 * `SFS_CLK_MHZ,
  parameter int ON_DELAY = `SFS_ON_DELAY_MS * 1000 * `SFS_CLK_MHZ,
  parameter int OFF_DELAY = `SFS_OFF_DELAY_MS * 1000 * `SFS_CLK_MHZ,
  parameter int RESTART = `SFS_RESTART_MS * 1000 * `SFS_CLK_MHZ,
  parameter int CFG_WAIT = `SFS_CFG_WAIT_MS * 1000 * `SFS_CLK_MHZ,
  parameter int OCP_TIME = `SFS_OCP_TIME_MS * 1000 * `SFS_CLK_MHZ,
  parameter int SS_STEP = `SFS_SS_STEP_US * `SFS_CLK_MHZ
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  input wire logic OV_IN,
  input wire logic UV_IN,
  input wire logic OC_IN,
  input wire logic OT_IN,
  input wire logic GND_FAULT_IN,
  input wire logic AUX_OV_IN,
  input wire logic AUX_LOCKOUT_IN,
  input wire logic REF_LOW_IN,
  input wire logic AC_SENSE_IN,
  input wire logic AC_SENSE_ALT_IN,
  input wire logic AC_LINK_IN,
  input wire logic PULSE_GOOD_IN,
  input wire logic CC_STATE_IN,
  input wire logic SUPPLY_ON_IN,
  output logic PEN_O,
  output logic PEN_OE,
  output logic CBD_O,
  output logic CBD_OE,
  output logic GATE_O,
  output logic GATE_OE,
  output logic DCOK_O,
  output logic DCOK_OE,
  output logic ACOK_O,
  output logic ACOK_OE,
  output logic [6:0] SS_REF
);
  localparam int NCH = 14;
  localparam int I_OV = 0;
  localparam int I_UV = 1;
  localparam int I_OC = 2;
  localparam int I_OT = 3;
  localparam int I_GND = 4;
  localparam int I_AOV = 5;
  localparam int I_ALO = 6;
  localparam int I_REF = 7;
  localparam int I_AC = 8;
  localparam int I_AC2 = 9;
  localparam int I_LNK = 10;
  localparam int I_PUL = 11;
  localparam int I_CC = 12;
  localparam int I_PS = 13;

  typedef struct packed {
    sfs_state_t st;
    sfs_drop_t drop;
    logic [NCH-1:0] s1;
    logic [NCH-1:0] s2;
    logic [NCH-1:0] deb;
    logic [NCH-1:0][22:0] dcnt;
    logic [25:0] tmr;
    logic [15:0] sscnt;
    logic [6:0] ss;
    logic [23:0] occnt;
    logic latch;
    logic ovp_hit;
    logic ac_prev;
    logic dcf;
    logic penf;
    logic [9:0] ctrl;
    logic [23:0] offd;
    logic [23:0] ocpt;
    logic [22:0] psond;
    logic [15:0] ssstep;
    logic ack;
    logic [31:0] rdat;
    logic pen_o, pen_oe, cbd_o, cbd_oe, gate_o, gate_oe;
    logic dc_o, dc_oe, ac_o, ac_oe;
  } sfs_reg_t;

  sfs_reg_t r;
  sfs_reg_t next_r;
  logic [NCH-1:0] raw;
  logic input_good_flag, blank, uv_fault, ovp_fault, oc_trip, clr, req;
  logic [31:0] wmask;
  logic [22:0] lim;
  logic [1:0] od;

  // open-drain good flag: returns {o, oe}
  function automatic logic [1:0] odrv(input logic flag, input logic inv, input logic pu);
    logic v;
    v = flag ^ inv;
    odrv = pu ? {1'b1, v} : {1'b0, ~v};
  endfunction

  assign raw = {SUPPLY_ON_IN, CC_STATE_IN, PULSE_GOOD_IN, AC_LINK_IN, AC_SENSE_ALT_IN,
                AC_SENSE_IN, REF_LOW_IN, AUX_LOCKOUT_IN, AUX_OV_IN, GND_FAULT_IN,
                OT_IN, OC_IN, UV_IN, OV_IN};

  always_comb
  begin
    next_r = r;
    lim = 23'h000000;
    od = 2'h0;
    next_r.s1 = raw; // [R24]
    next_r.s2 = r.s1; // [R24]
    for (int i = 0; i < NCH; i++)
    begin
      if (i == I_UV)
        lim = 23'(UV_DEB);
      else if (i == I_PS)
        lim = r.psond;
      else
        lim = 23'(OV_DEB);
      // count while the synchronised level disagrees with the filtered one
      if (r.s2[i] == r.deb[i]) // [R13] [R25]
        next_r.dcnt[i] = 23'h000000;
      else if (r.dcnt[i] + 23'h000001 >= lim)
      begin
        next_r.deb[i] = r.s2[i];
        next_r.dcnt[i] = 23'h000000;
      end
      else
        next_r.dcnt[i] = r.dcnt[i] + 23'h000001;
    end

    case (sfs_acsrc_t'(r.ctrl[`SFS_CTRL_SRC_LO +: 2])) // [R10]
      AC_CHIP: input_good_flag = r.deb[I_AC];
      AC_BUS: input_good_flag = r.ctrl[`SFS_CTRL_BUS_AC];
      AC_LINK: input_good_flag = r.deb[I_LNK];
      AC_ALT: input_good_flag = r.deb[I_AC2];
      default: input_good_flag = r.deb[I_AC];
    endcase

    next_r.occnt = r.deb[I_OC] ? ((r.occnt == 24'hFFFFFF) ? r.occnt : r.occnt + 24'h000001) : 24'h000000;
    oc_trip = r.deb[I_OC] && (r.occnt >= r.ocpt); // [R6]
    // ride-through keeps undervoltage quiet while current limit holds
    blank = (r.st != ST_RUN) || !input_good_flag || (r.deb[I_CC] && !oc_trip); // [R8] [R9]
    uv_fault = (r.deb[I_UV] && !blank) || r.deb[I_ALO]; // [R19]
    ovp_fault = r.deb[I_OV] || r.deb[I_AOV] || r.deb[I_GND]; // [R4] [R19] [R21]

    // wishbone slave: one wait state, ack drops after one cycle
    req = CYC_I && STB_I && !r.ack;
    next_r.ack = req;
    wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    clr = 1'b0;
    if (r.ack && CYC_I && STB_I && WE_I) // write lands on the edge the master samples ack
    begin
      case (ADR_I)
        `SFS_ADR_CTRL:
        begin
          next_r.ctrl = 10'((32'(r.ctrl) & ~wmask) | (DAT_I & wmask));
          next_r.ctrl[`SFS_CTRL_CLR] = 1'b0;
          clr = DAT_I[`SFS_CTRL_CLR] && SEL_I[1]; // [R5]
        end
        `SFS_ADR_OFFD: next_r.offd = 24'((32'(r.offd) & ~wmask) | (DAT_I & wmask)); // [R12]
        `SFS_ADR_OCPT: next_r.ocpt = 24'((32'(r.ocpt) & ~wmask) | (DAT_I & wmask)); // [R6]
        `SFS_ADR_PSOND: next_r.psond = 23'((32'(r.psond) & ~wmask) | (DAT_I & wmask)); // [R13]
        `SFS_ADR_SSSTEP: next_r.ssstep = 16'((32'(r.ssstep) & ~wmask) | (DAT_I & wmask));
        default: ;
      endcase
    end
    next_r.rdat = 32'h00000000;
    if (req && !WE_I)
    begin
      case (ADR_I)
        `SFS_ADR_CTRL: next_r.rdat = 32'(r.ctrl);
        `SFS_ADR_OFFD: next_r.rdat = 32'(r.offd);
        `SFS_ADR_OCPT: next_r.rdat = 32'(r.ocpt);
        `SFS_ADR_PSOND: next_r.rdat = 32'(r.psond);
        `SFS_ADR_SSSTEP: next_r.rdat = 32'(r.ssstep);
        `SFS_ADR_STATUS: next_r.rdat = {13'h0000, blank, r.deb[I_PS], input_good_flag, r.ss, r.ovp_hit, r.latch, r.st};
        default: next_r.rdat = 32'h00000000;
      endcase
    end

    // supply_on falling edge also clears the latch
    if (clr || (r.deb[I_PS] && !next_r.deb[I_PS])) // [R5]
    begin
      next_r.latch = 1'b0;
      next_r.ovp_hit = 1'b0;
    end
    next_r.ac_prev = input_good_flag;
    next_r.tmr = r.tmr + 26'h0000001;

    case (r.st)
      ST_CFG:
        if (r.tmr >= 26'(CFG_WAIT - 1)) // [R23]
        begin
          next_r.st = ST_OFF;
          next_r.tmr = 26'h0000000;
        end
      ST_OFF:
      begin
        next_r.tmr = 26'h0000000;
        if (r.deb[I_PS] && !r.latch && input_good_flag)
        begin
          next_r.st = ST_RAMP;
          next_r.ss = 7'h00;
          next_r.sscnt = 16'h0000;
        end
      end
      ST_RAMP:
      begin
        next_r.sscnt = r.sscnt + 16'h0001;
        if (r.sscnt + 16'h0001 >= r.ssstep) // [R18] [R25]
        begin
          next_r.sscnt = 16'h0000;
          if (r.ss != `SFS_SS_STEPS)
            next_r.ss = r.ss + 7'h01;
        end
        if (!r.deb[I_PS] || oc_trip || r.deb[I_OT] || r.deb[I_ALO])
        begin
          next_r.st = ST_DROP;
          next_r.tmr = 26'h0000000;
          next_r.drop = r.deb[I_ALO] ? DR_UV : (r.deb[I_PS] ? DR_FAULT : DR_SUPPLY_ON_REQUEST);
        end
        else if (r.ss == `SFS_SS_STEPS && r.tmr >= 26'(ON_DELAY - 1)) // [R11]
          next_r.st = ST_RUN;
      end
      ST_RUN:
      begin
        if (uv_fault) // [R2] [R3]
        begin
          next_r.st = ST_DROP;
          next_r.drop = DR_UV;
          next_r.tmr = 26'h0000000;
        end
        else if (oc_trip || r.deb[I_OT] || !r.deb[I_PS]) // [R6] [R7] [R12]
        begin
          next_r.st = ST_DROP;
          next_r.drop = r.deb[I_PS] ? DR_FAULT : DR_SUPPLY_ON_REQUEST;
          next_r.tmr = 26'h0000000;
        end
        else if (input_good_flag && !r.ac_prev) // [R15]
        begin
          next_r.st = ST_RAMP;
          next_r.ss = 7'h00;
          next_r.sscnt = 16'h0000;
          next_r.tmr = 26'h0000000;
        end
      end
      ST_DROP:
        if (r.tmr >= {2'h0, r.offd}) // [R12]
        begin
          next_r.tmr = 26'h0000000;
          if (r.drop == DR_SUPPLY_ON_REQUEST)
            next_r.st = ST_OFF;
          else if (r.drop == DR_UV && r.ctrl[`SFS_CTRL_AUTO]) // [R20]
            next_r.st = ST_RETRY;
          else
          begin
            next_r.st = ST_LATCH; // [R2] [R6] [R7]
            next_r.latch = 1'b1;
          end
        end
      ST_RETRY:
        if (r.tmr >= 26'(RESTART - 1)) // [R20]
        begin
          next_r.tmr = 26'h0000000;
          next_r.st = ST_OFF;
        end
      ST_LATCH:
      begin
        next_r.tmr = 26'h0000000;
        if (clr || (r.deb[I_PS] && !next_r.deb[I_PS])) // [R5]
          next_r.st = ST_OFF;
      end
      default: next_r.st = ST_OFF;
    endcase

    // overvoltage class wins over every state except ST_CFG and sets after any clear
    if (ovp_fault && r.st != ST_CFG) // [R4] [R5] [R21]
    begin
      next_r.st = ST_LATCH;
      next_r.latch = 1'b1;
      next_r.ovp_hit = 1'b1;
    end

    next_r.dcf = (next_r.st == ST_RUN); // [R3] [R11]
    next_r.penf = (next_r.st == ST_RAMP || next_r.st == ST_RUN || next_r.st == ST_DROP)
                  && !r.deb[I_REF]; // [R22]
    // pen, crowbar, gate: n-channel pull-down, released when inactive
    next_r.pen_o = 1'b0;
    next_r.pen_oe = next_r.penf;
    next_r.cbd_o = 1'b0;
    next_r.cbd_oe = next_r.ovp_hit; // [R4]
    next_r.gate_o = 1'b0;
    next_r.gate_oe = next_r.penf && next_r.st == ST_RUN && r.deb[I_PUL]; // [R16]
    od = odrv(next_r.dcf, r.ctrl[`SFS_CTRL_DC_INV], r.ctrl[`SFS_CTRL_DC_PU]); // [R14]
    next_r.dc_o = od[1];
    next_r.dc_oe = od[0];
    od = odrv(input_good_flag, r.ctrl[`SFS_CTRL_AC_INV], r.ctrl[`SFS_CTRL_AC_PU]); // [R14] [R17]
    next_r.ac_o = od[1];
    next_r.ac_oe = od[0];
    if (next_r.st == ST_CFG) // [R23]
    begin
      next_r.ac_oe = 1'b0;
      next_r.dc_oe = 1'b0;
    end

    if (RST) // [R1]
    begin
      next_r = '0;
      next_r.st = ST_CFG;
      next_r.drop = DR_SUPPLY_ON_REQUEST;
      next_r.ctrl = `SFS_CTRL_RST;
      next_r.offd = 24'(OFF_DELAY);
      next_r.ocpt = 24'(OCP_TIME);
      next_r.psond = 23'(SUPPLY_ON_REQUEST_DEB);
      next_r.ssstep = 16'(SS_STEP);
    end
  end

  always_ff @(posedge CLK)
  begin
    r <= next_r;
  end

  assign DAT_O = r.rdat;
  assign ACK_O = r.ack;
  assign PEN_O = r.pen_o;
  assign PEN_OE = r.pen_oe;
  assign CBD_O = r.cbd_o;
  assign CBD_OE = r.cbd_oe;
  assign GATE_O = r.gate_o;
  assign GATE_OE = r.gate_oe;
  assign DCOK_O = r.dc_o;
  assign DCOK_OE = r.dc_oe;
  assign ACOK_O = r.ac_o;
  assign ACOK_OE = r.ac_oe;
  assign SS_REF = r.ss;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  ovp_latch_a: assert property (ovp_fault && r.st != ST_CFG |=> r.st == ST_LATCH && r.latch && !r.penf) // [R4]
    else $error("overvoltage did not latch off");
  crowbar_fire_a: assert property ($rose(r.ovp_hit) |-> r.cbd_oe && !r.dcf) // [R4]
    else $error("crowbar or good flag wrong on overvoltage");
  uv_flag_a: assert property (r.st == ST_RUN && uv_fault && !ovp_fault |=> // [R3]
    r.st == ST_DROP && !r.dcf && r.penf == !$past(r.deb[I_REF]))
    else $error("good flag not dropped at once on undervoltage");
  latch_hold_a: assert property (r.st == ST_LATCH && !clr && !(r.deb[I_PS] && !next_r.deb[I_PS]) |=> r.st == ST_LATCH) // [R5]
    else $error("latch released without a clear");
  ramp_done_a: assert property ($rose(r.st == ST_RUN) |-> $past(r.ss) == `SFS_SS_STEPS) // [R18]
    else $error("run entered before ramp finished");
  blank_line_a: assert property (r.st == ST_RUN && !input_good_flag && !r.deb[I_ALO] |=> !(r.st == ST_DROP && r.drop == DR_UV)) // [R8]
    else $error("undervoltage acted while line low");
  gate_pulse_a: assert property (r.gate_oe |-> $past(r.deb[I_PUL]) && r.penf) // [R16]
    else $error("gate driven without good pulse");
  cfg_release_a: assert property (r.st == ST_CFG |-> !r.pen_oe && !r.cbd_oe && !r.gate_oe) // [R23]
    else $error("pin driven during configuration");
  ref_low_a: assert property (r.deb[I_REF] |=> !r.penf) // [R22]
    else $error("enable kept with low reference");
endmodule

// ==== verif/sfs_host_model.sv ====
/*
 * host-side model: status wiring and primary enable optocoupler.
 * assumes pull-ups on the open-drain status lines, so only the
 * pull-down drive mode of the good flags reads back correctly.
 */
module sfs_host_model
(
  input wire logic pen_o,
  input wire logic pen_oe,
  input wire logic cbd_o,
  input wire logic cbd_oe,
  input wire logic gate_o,
  input wire logic gate_oe,
  input wire logic dc_o,
  input wire logic dc_oe,
  input wire logic ac_o,
  input wire logic ac_oe,
  input wire logic line_ok,
  output logic pen_on,
  output logic cbd_on,
  output logic gate_on,
  output logic dc_lvl,
  output logic ac_lvl,
  output logic link
);
  timeunit 1ns;
  timeprecision 100ps;
  // opto lit only while the pin sinks current
  assign pen_on = pen_oe & ~pen_o;
  assign cbd_on = cbd_oe & ~cbd_o;
  assign gate_on = gate_oe & ~gate_o;
  // released line floats up, never holds its last value
  assign dc_lvl = dc_oe ? dc_o : 1'b1;
  assign ac_lvl = ac_oe ? ac_o : 1'b1;
  assign link = line_ok;
endmodule

// ==== verif/supply_fault_supervisor_tb.sv ====
/*
 * self-checking bench of the supply fault supervisor with shortened counts.
 * assumes sfs_host_model resolves the pins and the 1-cycle wishbone answer.
 */
`include "sfs_regs.svh"
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, a); end end
`define UNTIL(c) begin for (k = 0; k < 2000 && !(c); k++) @(posedge clk); \
  if (!(c)) begin n_fail++; $display("unexpected wait timeout"); test_done; end end
module supply_fault_supervisor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] dato;
  logic [31:0] q;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
  logic ov = 1'b0, uv = 1'b0, oc = 1'b0, ot = 1'b0, gnd = 1'b0, aov = 1'b0, alo = 1'b0;
  logic refl = 1'b0, acs = 1'b0, acalt = 1'b1, pg = 1'b0, cc = 1'b0, son = 1'b0;
  logic pen_o, pen_oe, cbd_o, cbd_oe, gate_o, gate_oe, dc_o, dc_oe, ac_o, ac_oe, link;
  logic pen_on, cbd_on, gate_on, dc_lvl, ac_lvl;
  logic [6:0] ss;
  int n_fail = 0;
  int compares = 0;
  int k;

  always #10 clk = ~clk;

  sfs_supervisor #(.OV_DEB(4), .UV_DEB(8), .SUPPLY_ON_REQUEST_DEB(8), .ON_DELAY(300), .OFF_DELAY(20),
    .RESTART(50), .CFG_WAIT(10), .OCP_TIME(10), .SS_STEP(2)) dut (.CLK(clk), .RST(rst),
    .ADR_I(adr), .DAT_I(dat), .DAT_O(dato), .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb),
    .ACK_O(ack), .OV_IN(ov), .UV_IN(uv), .OC_IN(oc), .OT_IN(ot), .GND_FAULT_IN(gnd),
    .AUX_OV_IN(aov), .AUX_LOCKOUT_IN(alo), .REF_LOW_IN(refl), .AC_SENSE_IN(acs),
    .AC_SENSE_ALT_IN(acalt), .AC_LINK_IN(link), .PULSE_GOOD_IN(pg), .CC_STATE_IN(cc),
    .SUPPLY_ON_IN(son), .PEN_O(pen_o), .PEN_OE(pen_oe), .CBD_O(cbd_o), .CBD_OE(cbd_oe),
    .GATE_O(gate_o), .GATE_OE(gate_oe), .DCOK_O(dc_o), .DCOK_OE(dc_oe), .ACOK_O(ac_o),
    .ACOK_OE(ac_oe), .SS_REF(ss));

  sfs_host_model host (.pen_o(pen_o), .pen_oe(pen_oe), .cbd_o(cbd_o), .cbd_oe(cbd_oe),
    .gate_o(gate_o), .gate_oe(gate_oe), .dc_o(dc_o), .dc_oe(dc_oe), .ac_o(ac_o),
    .ac_oe(ac_oe), .line_ok(acs), .pen_on(pen_on), .cbd_on(cbd_on), .gate_on(gate_on),
    .dc_lvl(dc_lvl), .ac_lvl(ac_lvl), .link(link));

  task test_done;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // entered just after a rising edge; read data lands in q
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
    q = dato;
    if (ack !== 1'b1)
    begin
      n_fail++;
      $display("unexpected bus timeout");
      test_done;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("pen_oe", 1'b0, pen_oe)
    `CHK("cbd_oe", 1'b0, cbd_oe)
    `CHK("gate_oe", 1'b0, gate_oe)
    wb(1'b0, `SFS_ADR_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, q)
    wb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, q)
    wb(1'b0, `SFS_ADR_STATUS, 32'h0);
    `CHK("latches", 2'h0, q[8:7])
    acs <= 1'b1;
    pg <= 1'b1;
    son <= 1'b1;
    `UNTIL(pen_on)
    `CHK("dc in ramp", 1'b0, dc_lvl)
    `UNTIL(dc_lvl)
    `CHK("on delay", 1'b1, k >= 299 && k <= 302)
    `CHK("ss top", 7'h7F, ss)
    `CHK("gate", 1'b1, gate_on)
    pg <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("gate off", 1'b0, gate_on)
    pg <= 1'b1;
    acs <= 1'b0;
    uv <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK("blanked", 1'b1, pen_on)
    `CHK("ac low", 1'b0, ac_lvl)
    uv <= 1'b0;
    repeat (20) @(posedge clk);
    acs <= 1'b1;
    `UNTIL(!dc_lvl)
    `UNTIL(dc_lvl)
    wb(1'b1, `SFS_ADR_CTRL, 32'h6);
    acalt <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("alt ac", 1'b0, ac_lvl)
    `CHK("alt dc", 1'b1, dc_lvl)
    acalt <= 1'b1;
    wb(1'b1, `SFS_ADR_CTRL, 32'h0);
    repeat (12) @(posedge clk);
    `UNTIL(dc_lvl)
    uv <= 1'b1;
    `UNTIL(!dc_lvl)
    `CHK("uv pen held", 1'b1, pen_on)
    `UNTIL(!pen_on)
    `CHK("uv off delay", 1'b1, k > 15 && k < 25)
    uv <= 1'b0;
    wb(1'b0, `SFS_ADR_STATUS, 32'h0);
    `CHK("uv latch", 1'b1, q[7])
    wb(1'b1, `SFS_ADR_CTRL, 32'h200);
    `UNTIL(dc_lvl)
    ot <= 1'b1;
    `UNTIL(!dc_lvl)
    `CHK("ot pen held", 1'b1, pen_on)
    `UNTIL(!pen_on)
    `CHK("ot off delay", 1'b1, k > 15)
    ot <= 1'b0;
    son <= 1'b0;
    repeat (30) @(posedge clk);
    son <= 1'b1;
    `UNTIL(dc_lvl)
    ov <= 1'b1;
    `UNTIL(cbd_on)
    `CHK("ov pen", 1'b0, pen_on)
    `CHK("ov dc", 1'b0, dc_lvl)
    ov <= 1'b0;
    wb(1'b1, `SFS_ADR_CTRL, 32'h1);
    repeat (60) @(posedge clk);
    wb(1'b0, `SFS_ADR_STATUS, 32'h0);
    `CHK("ov latch", 1'b1, q[8])
    son <= 1'b0;
    repeat (30) @(posedge clk);
    wb(1'b0, `SFS_ADR_STATUS, 32'h0);
    `CHK("ov cleared", 1'b0, q[8])
    son <= 1'b1;
    `UNTIL(dc_lvl)
    uv <= 1'b1;
    `UNTIL(!pen_on)
    uv <= 1'b0;
    `UNTIL(pen_on)
    `CHK("retry wait", 1'b1, k >= 50 && k <= 53)
    `UNTIL(dc_lvl)
    wb(1'b1, `SFS_ADR_CTRL, 32'h0);
    // current limit and undervoltage together; the shorter current-limit debounce blanks undervoltage before it lands
    cc <= 1'b1;
    uv <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK("cc blanked", 1'b1, pen_on && dc_lvl)
    uv <= 1'b0;
    repeat (20) @(posedge clk);
    cc <= 1'b0;
    repeat (10) @(posedge clk);
    wb(1'b1, `SFS_ADR_OCPT, 32'h28);
    wb(1'b0, `SFS_ADR_OCPT, 32'h0);
    `CHK("ocpt", 32'h28, q)
    oc <= 1'b1;
    `UNTIL(!dc_lvl)
    `CHK("oc time", 1'b1, k >= 46 && k <= 50)
    `CHK("oc pen held", 1'b1, pen_on)
    oc <= 1'b0;
    `UNTIL(!pen_on)
    wb(1'b0, `SFS_ADR_STATUS, 32'h0);
    `CHK("oc latch", 1'b1, q[7])
    wb(1'b1, `SFS_ADR_CTRL, 32'h200);
    `UNTIL(dc_lvl)
    gnd <= 1'b1;
    `UNTIL(cbd_on)
    `CHK("gnd pen", 1'b0, pen_on)
    gnd <= 1'b0;
    repeat (10) @(posedge clk);
    wb(1'b0, `SFS_ADR_STATUS, 32'h0);
    `CHK("gnd latch", 2'h3, q[8:7])
    wb(1'b1, `SFS_ADR_CTRL, 32'h200);
    `CHK("bus clear", 1'b0, cbd_on)
    `UNTIL(dc_lvl)
    aov <= 1'b1;
    `UNTIL(cbd_on)
    `CHK("aux ov dc", 1'b0, dc_lvl)
    aov <= 1'b0;
    repeat (10) @(posedge clk);
    wb(1'b1, `SFS_ADR_CTRL, 32'h200);
    `UNTIL(dc_lvl)
    alo <= 1'b1;
    `UNTIL(!dc_lvl)
    `CHK("lockout pen held", 1'b1, pen_on)
    alo <= 1'b0;
    `UNTIL(!pen_on)
    wb(1'b0, `SFS_ADR_STATUS, 32'h0);
    `CHK("lockout latch", 2'h1, q[8:7])
    wb(1'b1, `SFS_ADR_CTRL, 32'h200);
    `UNTIL(dc_lvl)
    wb(1'b1, `SFS_ADR_CTRL, 32'h90);
    repeat (3) @(posedge clk);
    `CHK("dc pull-up", 2'h3, {dc_o, dc_oe})
    `CHK("ac inverted", 1'b0, ac_lvl)
    wb(1'b1, `SFS_ADR_CTRL, 32'h20);
    repeat (3) @(posedge clk);
    `CHK("dc inverted", 1'b0, dc_lvl)
    refl <= 1'b1;
    `UNTIL(!pen_on)
    `CHK("ref low", 1'b1, k < 20)
    wb(1'b1, `SFS_ADR_CTRL, 32'h4);
    acs <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("link line", 1'b0, ac_lvl)
    wb(1'b1, `SFS_ADR_CTRL, 32'hA);
    repeat (3) @(posedge clk);
    `CHK("bus line high", 1'b1, ac_lvl)
    wb(1'b1, `SFS_ADR_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    `CHK("bus line low", 1'b0, ac_lvl)
    test_done;
  end
endmodule
